// File: common/acg_consts.vh
`ifndef ACG_CONSTS_VH
`define ACG_CONSTS_VH
`define ACG_SRC_MCLK        2'h0
`define ACG_SRC_BCLK        2'h1
`define ACG_SRC_PIN2        2'h2
`define ACG_GP1_INPUT       2'h0
`define ACG_GP1_CLKOUT      2'h1
`define ACG_GP1_ADC_FRAME   2'h2
`define ACG_MCLK_PER_REF    9'h100
`define ACG_REF_DIV_LOG2    8
`define ACG_NOPLL_INC       26'h0000002
`define ACG_CLKOUT_INC      26'h0000004
`define ACG_FRAC_SCALE      26'h0002710
`define ACG_PLL_DIV         26'h0000008
`define ACG_Q_MIN           5'h02
`define ACG_Q_MAX           5'h11
`define ACG_P_MIN           4'h1
`define ACG_P_MAX           4'h8
`define ACG_R_MIN           5'h01
`define ACG_R_MAX           5'h10
`define ACG_J_MIN           6'h01
`define ACG_D_MAX           14'h270F
`define ACG_N_MIN           5'h02
`define ACG_N_MAX           5'h11
`define ACG_RATIO_MIN       4'h2
`define ACG_RATIO_MAX       4'hC
`define ACG_FRAME_SINGLE    11'h080
`define ACG_FRAME_DUAL      11'h040
`endif

// File: logic/acg_clock_gen.v
`timescale 1ns/1ps
`include "acg_consts.vh"
module acg_clock_gen (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        mclk,
    input  wire        bclk,
    input  wire        gp2_in,
    input  wire        gp1_in,
    input  wire        pll_enable,
    input  wire [1:0]  divider_source_clock,
    input  wire [1:0]  pll_source_clock,
    input  wire [4:0]  div_q,
    input  wire [3:0]  pll_p,
    input  wire [4:0]  pll_r,
    input  wire [5:0]  pll_j,
    input  wire [13:0] pll_d,
    input  wire        clock_output_source_select,
    input  wire [1:0]  clkout_m_code,
    input  wire [4:0]  clkout_n,
    input  wire [3:0]  dac_rate_ratio,
    input  wire [3:0]  adc_rate_ratio,
    input  wire        dac_dual,
    input  wire        adc_dual,
    input  wire        conv_powered,
    input  wire [1:0]  gp1_func,
    output reg         conv_mclk_tick,
    output reg         fs_ref_tick,
    output reg         dac_frame_tick,
    output reg         adc_frame_tick,
    output reg         adc_mod_tick,
    output reg         word_clock,
    output reg         gp1_out,
    output reg         gp1_oe_n
);

    // Previous samples of the three candidate clock inputs
    reg        mclk_q;
    reg        bclk_q;
    reg        pin2_q;
    // Rising edges; the inputs are already synchronous to sys_clk
    wire       mclk_rise = mclk & ~mclk_q;
    wire       bclk_rise = bclk & ~bclk_q;
    wire       pin2_rise = gp2_in & ~pin2_q;

    // Active (shadow) settings, only reloaded on a tick boundary or while the synthesiser is idle
    reg        pll_en_q;
    reg [1:0]  div_src_q;
    reg [1:0]  pll_src_q;
    reg [4:0]  q_q;
    reg [3:0]  p_q;
    reg [4:0]  r_q;
    reg [5:0]  j_q;
    reg [13:0] d_q;
    reg        mux_q;
    reg [3:0]  m_q;
    reg [4:0]  n_q;

    // Clamped requests, so a bad value never yields a zero divisor
    wire [4:0]  q_c = (div_q < `ACG_Q_MIN) ? `ACG_Q_MIN :
                      (div_q > `ACG_Q_MAX) ? `ACG_Q_MAX : div_q;
    wire [3:0]  p_c = (pll_p < `ACG_P_MIN) ? `ACG_P_MIN :
                      (pll_p > `ACG_P_MAX) ? `ACG_P_MAX : pll_p;
    wire [4:0]  r_c = (pll_r < `ACG_R_MIN) ? `ACG_R_MIN :
                      (pll_r > `ACG_R_MAX) ? `ACG_R_MAX : pll_r;
    wire [5:0]  j_c = (pll_j < `ACG_J_MIN) ? `ACG_J_MIN : pll_j;
    wire [13:0] d_c = (pll_d > `ACG_D_MAX) ? `ACG_D_MAX : pll_d;
    wire [4:0]  n_c = (clkout_n < `ACG_N_MIN) ? `ACG_N_MIN :
                      (clkout_n > `ACG_N_MAX) ? `ACG_N_MAX : clkout_n;
    wire [3:0]  m_c = 4'h1 << clkout_m_code;

    reg div_edge;
    always @* begin
        case (div_src_q)
            `ACG_SRC_MCLK: div_edge = mclk_rise;
            `ACG_SRC_BCLK: div_edge = bclk_rise;
            `ACG_SRC_PIN2: div_edge = pin2_rise;
            default:       div_edge = mclk_rise;
        endcase
    end

    // PLL input select; pin two also allowed for pass-through use
    reg pll_edge;
    always @* begin
        case (pll_src_q)
            `ACG_SRC_MCLK: pll_edge = mclk_rise;
            `ACG_SRC_BCLK: pll_edge = bclk_rise;
            `ACG_SRC_PIN2: pll_edge = pin2_rise;
            default:       pll_edge = mclk_rise;
        endcase
    end

    // Multiplier K*R scaled by 10000, used by both synthesisers
    // J.D fractional multiplier
    wire [25:0] k_scaled = {20'h00000, j_q} * `ACG_FRAC_SCALE + {12'h000, d_q};
    wire [25:0] kr_scaled = k_scaled * {21'h000000, r_q};

    // Converter master clock synthesiser: ticks at 256 x reference
    // PLL ratio KR/(8P) on master
    wire [25:0] cm_inc = pll_en_q ? kr_scaled : `ACG_NOPLL_INC;
    wire [25:0] cm_thr = pll_en_q ?
                         (`ACG_PLL_DIV * `ACG_FRAC_SCALE * {22'h000000, p_q}) :
                         {21'h000000, q_q};
    wire        cm_edge = pll_en_q ? pll_edge : div_edge;
    reg  [26:0] cm_acc_q;
    // A backlog past 2^26 drops further edges: the output already ticks on
    // every sys_clk, and without this a saturated sum would wrap round
    wire [26:0] cm_sum = cm_acc_q + ((cm_edge & ~cm_acc_q[26]) ? {1'b0, cm_inc} : 27'h0000000);
    // Excess drains one tick per sys_clk; output rate saturates at sys_clk
    wire        cm_hit = (cm_sum >= {1'b0, cm_thr});

    // Pin one clock output synthesiser: ticks at twice the pin frequency
    // mux one: 4/(M*N) ticks per edge
    wire        co_pll = ~mux_q & pll_en_q;
    wire [25:0] mn     = {22'h000000, m_q} * {21'h000000, n_q};
    // Twice the pin frequency: 4*K*R scaled, over M*N*P scaled
    wire [25:0] co_inc = co_pll ? {kr_scaled[23:0], 2'b00} : `ACG_CLKOUT_INC;
    wire [25:0] co_thr = co_pll ? (mn * `ACG_FRAC_SCALE * {22'h000000, p_q}) : mn;
    wire        co_edge = co_pll ? pll_edge : div_edge;
    reg  [26:0] co_acc_q;
    // Same backlog limit as the master synthesiser
    wire [26:0] co_sum = co_acc_q + ((co_edge & ~co_acc_q[26]) ? {1'b0, co_inc} : 27'h0000000);
    wire        co_hit = (co_sum >= {1'b0, co_thr});
    reg         co_level_q;

    // Settings load only on a synthesiser tick or while it is idle,
    // so a changed ratio never cuts a half-period short
    // glitch-free reload
    wire        cm_load = cm_hit | (cm_acc_q == 27'h0000000);
    wire        co_load = co_hit | (co_acc_q == 27'h0000000);

    // Input edge history; runs through reset so that a pin already high
    // at release is not taken for a fresh rising edge
    always @(posedge sys_clk) begin
        mclk_q <= mclk;
        bclk_q <= bclk;
        pin2_q <= gp2_in;
    end

    // Shadow settings reload
    always @(posedge sys_clk) begin
        if (rst) begin
            pll_en_q  <= 1'b0;
            div_src_q <= `ACG_SRC_MCLK;
            pll_src_q <= `ACG_SRC_MCLK;
            q_q       <= `ACG_Q_MIN;
            p_q       <= `ACG_P_MIN;
            r_q       <= `ACG_R_MIN;
            j_q       <= `ACG_J_MIN;
            d_q       <= 14'h0000;
            mux_q     <= 1'b0;
            m_q       <= 4'h1;
            n_q       <= `ACG_N_MIN;
        end else begin
            // Shared fields change only when both synthesisers agree
            if (cm_load & co_load) begin
                pll_en_q  <= pll_enable;
                div_src_q <= divider_source_clock;
                pll_src_q <= pll_source_clock;
                p_q       <= p_c;
                r_q       <= r_c;
                j_q       <= j_c;
                d_q       <= d_c;
            end
            if (cm_load) begin
                q_q <= q_c;
            end
            if (co_load) begin
                mux_q <= clock_output_source_select;
                m_q   <= m_c;
                n_q   <= n_c;
            end
        end
    end

    // Phase accumulators for both synthesisers
    // external clock drives both
    always @(posedge sys_clk) begin
        if (rst) begin
            cm_acc_q   <= 27'h0000000;
            co_acc_q   <= 27'h0000000;
            co_level_q <= 1'b0;
        end else begin
            cm_acc_q <= cm_hit ? (cm_sum - {1'b0, cm_thr}) : cm_sum;
            co_acc_q <= co_hit ? (co_sum - {1'b0, co_thr}) : co_sum;
            // clock out runs regardless of converter power
            if (co_hit) begin
                co_level_q <= ~co_level_q;
            end
        end
    end

    // Reference and frame dividers, counted in master ticks
    reg  [7:0]  ref_cnt_q;
    reg  [10:0] dac_cnt_q;
    reg  [10:0] adc_cnt_q;
    reg         mod_ph_q;
    reg         adc_level_q;
    wire [3:0]  dac_n2 = (dac_rate_ratio < `ACG_RATIO_MIN) ? `ACG_RATIO_MIN :
                         (dac_rate_ratio > `ACG_RATIO_MAX) ? `ACG_RATIO_MAX : dac_rate_ratio;
    wire [3:0]  adc_n2 = (adc_rate_ratio < `ACG_RATIO_MIN) ? `ACG_RATIO_MIN :
                         (adc_rate_ratio > `ACG_RATIO_MAX) ? `ACG_RATIO_MAX : adc_rate_ratio;
    // frame length 128*2N or 64*2N master ticks
    wire [10:0] dac_len = (dac_dual ? `ACG_FRAME_DUAL : `ACG_FRAME_SINGLE) * {7'h00, dac_n2};
    wire [10:0] adc_len = (adc_dual ? `ACG_FRAME_DUAL : `ACG_FRAME_SINGLE) * {7'h00, adc_n2};
    wire        run = conv_powered & cm_hit;
    wire        dac_end = (dac_cnt_q >= dac_len - 11'h001);
    wire        adc_end = (adc_cnt_q >= adc_len - 11'h001);

    // Converter timing chain, held while the converters are powered down
    always @(posedge sys_clk) begin
        if (rst) begin
            ref_cnt_q      <= 8'h00;
            dac_cnt_q      <= 11'h000;
            adc_cnt_q      <= 11'h000;
            mod_ph_q       <= 1'b0;
            adc_level_q    <= 1'b0;
            conv_mclk_tick <= 1'b0;
            fs_ref_tick    <= 1'b0;
            dac_frame_tick <= 1'b0;
            adc_frame_tick <= 1'b0;
            adc_mod_tick   <= 1'b0;
            word_clock     <= 1'b0;
        end else begin
            conv_mclk_tick <= run;
            fs_ref_tick    <= run & (ref_cnt_q == 8'hFF);
            dac_frame_tick <= run & (dac_cnt_q == 11'h000);
            adc_frame_tick <= run & (adc_cnt_q == 11'h000);
            adc_mod_tick   <= run & (adc_dual | mod_ph_q);
            if (run) begin
                ref_cnt_q <= ref_cnt_q + 8'h01;
                mod_ph_q  <= ~mod_ph_q;
                dac_cnt_q <= dac_end ? 11'h000 : dac_cnt_q + 11'h001;
                adc_cnt_q <= adc_end ? 11'h000 : adc_cnt_q + 11'h001;
                // word clock high for first half of frame
                word_clock  <= (dac_cnt_q < {1'b0, dac_len[10:1]});
                adc_level_q <= (adc_cnt_q < {1'b0, adc_len[10:1]});
            end
        end
    end

    // General pin one driver; enable is active low
    always @(posedge sys_clk) begin
        if (rst) begin
            gp1_out  <= 1'b0;
            gp1_oe_n <= 1'b1;
        end else begin
            case (gp1_func)
                `ACG_GP1_CLKOUT: begin
                    gp1_out  <= co_level_q;
                    gp1_oe_n <= 1'b0;
                end
                `ACG_GP1_ADC_FRAME: begin
                    gp1_out  <= adc_level_q;
                    gp1_oe_n <= 1'b0;
                end
                default: begin
                    gp1_out  <= 1'b0;
                    gp1_oe_n <= 1'b1;
                end
            endcase
        end
    end

endmodule // acg_clock_gen

// File: test/acg_properties.sv
`timescale 1ns/1ps
// Tick relations of the generator, seen at its ports
module acg_properties (
    input wire       sys_clk,
    input wire       rst,
    input wire       conv_powered,
    input wire       adc_dual,
    input wire [1:0] gp1_func,
    input wire       conv_mclk_tick,
    input wire       fs_ref_tick,
    input wire       dac_frame_tick,
    input wire       adc_frame_tick,
    input wire       adc_mod_tick,
    input wire       gp1_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    reg [7:0] mcnt_q = 8'h00; // Master ticks since the reference tick
    reg       seen_q = 1'b0;  // Count valid; power-down clears the count
    // Count master ticks between reference ticks
    always @(posedge sys_clk) begin
        if (rst || !conv_powered) begin
            mcnt_q <= 8'h00;
            seen_q <= 1'b0;
        end else if (fs_ref_tick) begin
            mcnt_q <= 8'h00;
            seen_q <= 1'b1;
        end else begin
            mcnt_q <= mcnt_q + {7'h00, conv_mclk_tick};
        end
    end
    chk_ref_on_mclk: assert property (fs_ref_tick |-> conv_mclk_tick)
        else $error("reference tick alone");
    chk_ref_count: assert property (fs_ref_tick && seen_q |-> mcnt_q == 8'hFF)
        else $error("reference tick not 256 master ticks");
    chk_off_quiet: assert property (
        !conv_powered && !$past(conv_powered) && !$past(conv_powered, 2)
        |-> !(dac_frame_tick || adc_frame_tick || adc_mod_tick))
        else $error("converter tick while off");
    chk_pin_free: assert property (
        gp1_func == 2'h0 && $past(gp1_func) == 2'h0 |-> gp1_oe_n)
        else $error("pin one driven as input");
    chk_pin_drive: assert property (
        !$past(rst) && gp1_func != 2'h0 && $past(gp1_func) != 2'h0 |-> !gp1_oe_n)
        else $error("pin one not driven");
    chk_dac_gap: assert property (dac_frame_tick |=> !dac_frame_tick [*8])
        else $error("dac frames too close");
    chk_adc_gap: assert property (adc_frame_tick |=> !adc_frame_tick [*8])
        else $error("adc frames too close");
    chk_mod_half: assert property (adc_mod_tick && !adc_dual |=> !adc_mod_tick)
        else $error("modulator too fast");
endmodule // acg_properties
bind acg_clock_gen acg_properties acg_properties_i (
    .sys_clk(sys_clk), .rst(rst), .conv_powered(conv_powered), .adc_dual(adc_dual),
    .gp1_func(gp1_func), .conv_mclk_tick(conv_mclk_tick), .fs_ref_tick(fs_ref_tick),
    .dac_frame_tick(dac_frame_tick), .adc_frame_tick(adc_frame_tick),
    .adc_mod_tick(adc_mod_tick), .gp1_oe_n(gp1_oe_n));

// File: test/acg_src_model.sv
`timescale 1ns/1ps
// Far side: three free-running audio clocks, periods of 4, 6 and 8 cycles
module acg_src_model (
    input  wire sys_clk,
    output reg  mclk = 1'b0,
    output reg  bclk = 1'b0,
    output reg  gp2  = 1'b0
);
    reg [4:0] ph_q = 5'h00; // Phase in a 24-cycle common period
    reg [2:0] bp_q = 3'h0;  // Phase in the 6-cycle bit clock period
    always @(posedge sys_clk) begin
        ph_q <= (ph_q == 5'h17) ? 5'h00 : ph_q + 5'h01;
        bp_q <= (bp_q == 3'h5) ? 3'h0 : bp_q + 3'h1;
        mclk <= ph_q[1];
        bclk <= (bp_q < 3'h3);
        gp2  <= ph_q[2];
    end
endmodule // acg_src_model

// File: test/test_acg_clock_gen.sv
`timescale 1ns/1ps
module test_acg_clock_gen;
    reg         sys_clk = 1'b0;
    reg         rst = 1'b1;
    reg         pll_en = 1'b0, mux = 1'b1, pwr = 1'b1, dual_d = 1'b0, dual_a = 1'b0;
    reg  [1:0]  src = 2'h0, mc = 2'h0, func = 2'h1;
    reg  [4:0]  q = 5'h02, r = 5'h01, n = 5'h02;
    reg  [3:0]  p = 4'h1, nd = 4'h2, na = 4'h2;
    reg  [5:0]  j = 6'h01;
    reg  [13:0] d = 14'h0000;
    reg  [95:0] rows [0:9]; // Settings beside expected tick and pin-rise counts
    reg         g_last, w_last;
    wire        mclk, bclk, gp2, t_m, t_ref, t_df, t_af, t_mod, wc, g_out, g_oe_n;
    integer     n_errors = 0, n_compared = 0, i, cm, cg, cw;
    always #5 sys_clk = ~sys_clk;
    acg_src_model acg_src_model_i (.sys_clk(sys_clk), .mclk(mclk), .bclk(bclk), .gp2(gp2));
    acg_clock_gen acg_clock_gen_i (
        .sys_clk(sys_clk), .rst(rst), .mclk(mclk), .bclk(bclk), .gp2_in(gp2), .gp1_in(1'b0),
        .pll_enable(pll_en), .divider_source_clock(src), .pll_source_clock(src), .div_q(q),
        .pll_p(p), .pll_r(r), .pll_j(j), .pll_d(d), .clock_output_source_select(mux),
        .clkout_m_code(mc), .clkout_n(n), .dac_rate_ratio(nd), .adc_rate_ratio(na),
        .dac_dual(dual_d), .adc_dual(dual_a), .conv_powered(pwr), .gp1_func(func),
        .conv_mclk_tick(t_m), .fs_ref_tick(t_ref), .dac_frame_tick(t_df),
        .adc_frame_tick(t_af), .adc_mod_tick(t_mod), .word_clock(wc), .gp1_out(g_out),
        .gp1_oe_n(g_oe_n));
    // Counts are allowed two ticks of slack for window edges and fractions
    task chk(input integer got, input integer exp);
        begin
            n_compared = n_compared + 1;
            if (got < exp - 2 || got > exp + 2) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task chkv(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d compared %0d", n_errors, n_compared);
            if (n_errors == 0 && n_compared > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    // Apply one row, let it settle, count over 2400 cycles
    task run_row(input [95:0] w);
        begin
            {pll_en, src, q, p, r, j} = {w[92], w[89:88], w[84:80], w[79:76], w[72:68], w[65:60]};
            {d, mux, mc, n, pwr} = {w[57:44], w[40], w[37:36], w[32:28], w[24]};
            repeat (300) @(posedge sys_clk);
            {cm, cg, g_last} = {32'h0, 32'h0, g_out};
            repeat (2400) begin
                @(posedge sys_clk);
                #1;
                cm = cm + (t_m === 1'b1);
                cg = cg + (g_out === 1'b1 && g_last === 1'b0);
                g_last = g_out;
            end
            if (w[23:12] != 12'hFFF) begin
                chk(cm, w[23:12]);
            end
            chk(cg, w[11:0]);
        end
    endtask
    // Cycles between the second and third frame ticks, master tick every cycle
    task automatic meas(input s, input integer e);
        integer k, f;
        begin
            {k, f} = {32'h0, 32'h0};
            while (f < 3) begin
                @(posedge sys_clk);
                #1;
                k = k + (f == 2);
                f = f + ((s ? t_af : t_df) === 1'b1);
            end
            chk(k, e);
        end
    endtask
    initial begin
        // rows keep host limits on Q, J, R and D
        rows[0] = 96'h0_0_02_1_01_01_0000_1_0_02_1_258_258;
        rows[1] = 96'h0_1_02_1_01_01_0000_1_1_03_1_190_085;
        rows[2] = 96'h0_2_05_1_01_01_0000_1_2_11_1_078_009;
        rows[3] = 96'h0_3_11_1_01_01_0000_1_3_02_1_047_04B;
        rows[4] = 96'h1_0_02_1_01_08_0000_0_3_10_1_258_04B;
        rows[5] = 96'h1_0_02_1_01_04_1388_0_0_09_1_152_258;
        rows[6] = 96'h1_1_02_2_02_08_0000_1_0_02_1_190_190;
        rows[7] = 96'h1_2_02_3_01_0B_09C4_0_1_05_1_08D_0E1;
        rows[8] = 96'h1_0_02_8_01_0B_270F_0_0_11_1_070_06A;
        rows[9] = 96'h1_2_02_8_10_04_0000_0_0_08_0_FFF_258;
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        for (i = 0; i < 10; i = i + 1) begin
            run_row(rows[i]);
        end
        // saturated master, differing rates, frame clock on pin one
        {pll_en, src, mux, pwr, p, r, j, d, func} =
            {1'b1, 2'h0, 1'b1, 1'b1, 4'h1, 5'h10, 6'h37, 14'h0000, 2'h2};
        repeat (300) @(posedge sys_clk);
        #1;
        for (i = 2; i < 13; i = i + 1) begin
            {nd, na, dual_d} = {i[3:0], 4'hE - i[3:0], i[0]};
            fork
                meas(1'b0, (i[0] ? 64 : 128) * i);
                meas(1'b1, 128 * (14 - i));
            join
        end
        // dual-rate ADC: modulator, frame clock, word clock
        dual_a = 1'b1;
        repeat (300) @(posedge sys_clk);
        #1;
        {cm, cg, cw, g_last, w_last} = {96'h0, g_out, wc};
        repeat (6144) begin
            @(posedge sys_clk);
            #1;
            cm = cm + (t_mod === 1'b1);
            cg = cg + (g_out === 1'b1 && g_last === 1'b0);
            cw = cw + (wc === 1'b1 && w_last === 1'b0);
            {g_last, w_last} = {g_out, wc};
        end
        chk(cm, 6144);
        chk(cg, 48);
        chk(cw, 4);
        func = 2'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        chkv({7'h00, g_oe_n}, 8'h01);
        func = 2'h1;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chkv({t_m, t_ref, t_df, t_af, t_mod, wc, g_out, g_oe_n}, 8'h01);
        stop_test;
    end
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        stop_test;
    end
endmodule // test_acg_clock_gen
